// ==== logic/cdde_cfg.svh ====
// offsets, field positions and reset values of the descriptor engine
`ifndef CDDE_CFG_SVH
`define CDDE_CFG_SVH
`define CDDE_AW            7
`define CDDE_RPT_LO_OFS    7'h20
`define CDDE_RPT_HI_OFS    7'h24
`define CDDE_CTRL_OFS      7'h28
`define CDDE_STAT_OFS      7'h2C
`define CDDE_ISTAT_OFS     7'h30
`define CDDE_IMASK_OFS     7'h34
`define CDDE_HW_COUNT      2'h0
`define CDDE_HW_BASE_HI    2'h1
`define CDDE_HW_BASE_LO    2'h2
`define CDDE_HW_READY      2'h3
`define CDDE_F_DIR         16
`define CDDE_F_HMSI        17
`define CDDE_F_HRPT        18
`define CDDE_F_MSINUM      24:20
`define CDDE_F_MSITC       30:28
`define CDDE_F_DRPT        16
`define CDDE_F_DMSI        17
`define CDDE_F_LEN         15:0
`define CDDE_F_CNT         15:0
`define CDDE_DESC_BYTES    64'h0000_0000_0000_0010
`define CDDE_IRQ_DESC      0
`define CDDE_IRQ_TABLE     1
`define CDDE_RST32         32'h0000_0000
`endif

// ==== logic/cdde_pkg.sv ====
// types and shared decoding of the descriptor engine
package cdde_pkg;
  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_HRD   = 4'h1,
    S_HCAP  = 4'h2,
    S_CHECK = 4'h3,
    S_FETCH = 4'h4,
    S_FWAIT = 4'h5,
    S_XFER  = 4'h6,
    S_RPT   = 4'h7,
    S_MSI   = 4'h8,
    S_NEXT  = 4'h9
  } cdde_state_t;

  // true when a bus address falls in the two header blocks
  function automatic logic cdde_is_hdr(input logic [6:0] a);
    return a[6:5] == 2'h0;
  endfunction
endpackage

// ==== logic/cdde_hdr_mem.sv ====
// two four-word descriptor headers with registered read data
`include "cdde_cfg.svh"
`timescale 1ns/100ps
module cdde_hdr_mem (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  input  wire logic [2:0]  rd_addr,
  input  wire logic        byp_sel,
  input  wire logic [31:0] byp_data,
  output logic      [31:0] rd_data_r
);
  logic [31:0] mem [0:7];

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_word
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          mem[g] <= `CDDE_RST32;
        end else if (wr_en && wr_addr == 3'(g)) begin
          mem[g] <= wr_data;
        end
      end
    end
  endgenerate

  // bypass lets non-header registers share the one output flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_r <= `CDDE_RST32;
    end else begin
      rd_data_r <= byp_sel ? byp_data : mem[rd_addr];
    end
  end
endmodule // cdde_hdr_mem

// ==== logic/cdde_engine.sv ====
// chaining dma descriptor engine: header registers, fetch, transfer, report, msi
//
// How it works
// - descriptor is four words: length/flags, endpoint addr, host addr high, host addr low.
// - one transfer per descriptor using that descriptor's fields, with direction from the header.
// - length field counts bytes.
// - second word is the full 32-bit endpoint start address.
// - host start address is upper and lower words joined to 64 bits.
// - report enable is descriptor bit 16 OR header report enable.
// - when report enabled, write zero-based index of last finished descriptor to host.
// - interrupt enable is descriptor bit 17 OR header interrupt enable.
// - when interrupt enabled, send msi after that descriptor's transfer ends.
// - descriptors live in host memory and are only ever read.
// - control space fits a 128-byte memory window.
// - descriptor count comes from header word 0 bits 15 to 0.
// - header direction bit set routes to host writes, clear to host reads.
// - only descriptors whose zero-based index is at most the host ready count are processed.
// - table base from header words 1 and 2; headers at 0x00 and 0x10.
`include "cdde_cfg.svh"
`timescale 1ns/100ps
module cdde_engine (
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  input  wire logic [6:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic             DESC_RD_REQ,
  output logic      [63:0] DESC_RD_ADDR,
  input  wire logic        DESC_VALID,
  input  wire logic [31:0] DESC_DATA,
  output logic             XFER_REQ,
  output logic             XFER_TO_HOST,
  output logic      [31:0] XFER_EP_ADDR,
  output logic      [63:0] XFER_HOST_ADDR,
  output logic      [15:0] XFER_BYTES,
  input  wire logic        XFER_DONE,
  output logic             RPT_REQ,
  output logic      [63:0] RPT_ADDR,
  output logic      [15:0] RPT_DATA,
  input  wire logic        RPT_ACK,
  output logic             MSI_REQ,
  output logic      [4:0]  MSI_NUM,
  output logic      [2:0]  MSI_TC,
  input  wire logic        MSI_ACK,
  output logic             IRQ
);
  cdde_pkg::cdde_state_t state_r;
  logic        tbl_r;
  logic [1:0]  sel_r;
  logic [1:0]  wcnt_r;
  logic [15:0] idx_r;
  logic [31:0] hdr_ctl_r;
  logic [63:0] base_r;
  logic [15:0] ready_r;
  logic [31:0] d_w_r [0:2];
  logic [1:0]  start_pend_r;
  logic [63:0] rpt_loc_r;
  logic [1:0]  istat_r;
  logic [1:0]  imask_r;
  logic [1:0]  ev;
  logic        take0;
  logic        take1;
  logic        busy;
  logic        rpt_en;
  logic        msi_en;
  logic        hdr_wr;
  logic [31:0] byp_data;
  logic [31:0] mem_q;

  assign busy   = state_r != cdde_pkg::S_IDLE;
  assign take0  = !busy && start_pend_r[0];
  assign take1  = !busy && !start_pend_r[0] && start_pend_r[1];
  // only bits 17:16 of the flag word count; 31:18 are dropped here
  assign rpt_en = d_w_r[0][`CDDE_F_DRPT] | hdr_ctl_r[`CDDE_F_HRPT];
  assign msi_en = d_w_r[0][`CDDE_F_DMSI] | hdr_ctl_r[`CDDE_F_HMSI];
  assign hdr_wr = WR && cdde_pkg::cdde_is_hdr(ADDR);

  // local register readback; unmapped words read zero
  always_comb begin
    byp_data = `CDDE_RST32;
    unique case (ADDR)
      `CDDE_RPT_LO_OFS: byp_data = rpt_loc_r[31:0];
      `CDDE_RPT_HI_OFS: byp_data = rpt_loc_r[63:32];
      `CDDE_CTRL_OFS:   byp_data = {30'h0, start_pend_r};
      `CDDE_STAT_OFS:   byp_data = {busy, tbl_r, 14'h0, idx_r};
      `CDDE_ISTAT_OFS:  byp_data = {30'h0, istat_r};
      `CDDE_IMASK_OFS:  byp_data = {30'h0, imask_r};
      default:          byp_data = `CDDE_RST32;
    endcase
  end

  // engine reads header words only when the bus is not reading
  cdde_hdr_mem u_hdr (
    .clk       (CLOCK),
    .rst_n     (RESET_N),
    .wr_en     (hdr_wr),
    .wr_addr   (ADDR[4:2]),
    .wr_data   (WDATA),
    .rd_addr   (RD ? ADDR[4:2] : {tbl_r, sel_r}),
    .byp_sel   (RD && !cdde_pkg::cdde_is_hdr(ADDR)),
    .byp_data  (byp_data),
    .rd_data_r (mem_q)
  );
  assign RDATA = mem_q;

  // software registers
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      rpt_loc_r <= 64'h0;
      imask_r   <= 2'h0;
    end else if (WR) begin
      if (ADDR == `CDDE_RPT_LO_OFS) rpt_loc_r[31:0] <= WDATA;
      if (ADDR == `CDDE_RPT_HI_OFS) rpt_loc_r[63:32] <= WDATA;
      if (ADDR == `CDDE_IMASK_OFS) imask_r <= WDATA[1:0];
    end
  end

  // start requests; a new start wins over the engine taking it
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      start_pend_r <= 2'h0;
    end else begin
      start_pend_r <= (start_pend_r & ~{take1, take0})
                    | ((WR && ADDR == `CDDE_CTRL_OFS) ? WDATA[1:0] : 2'h0);
    end
  end

  // sticky events, write one to clear, set wins
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      istat_r <= 2'h0;
      IRQ     <= 1'b0;
    end else begin
      istat_r <= (istat_r & ~((WR && ADDR == `CDDE_ISTAT_OFS) ? WDATA[1:0] : 2'h0)) | ev;
      IRQ     <= |(istat_r & imask_r);
    end
  end

  always_comb begin
    ev = 2'h0;
    ev[`CDDE_IRQ_DESC]  = state_r == cdde_pkg::S_XFER && XFER_DONE;
    ev[`CDDE_IRQ_TABLE] = state_r == cdde_pkg::S_CHECK &&
                          !(idx_r < hdr_ctl_r[`CDDE_F_CNT] && idx_r <= ready_r);
  end

  // sequencer
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      state_r <= cdde_pkg::S_IDLE;
      tbl_r   <= 1'b0;
      sel_r   <= 2'h0;
      wcnt_r  <= 2'h0;
      idx_r   <= 16'h0;
    end else begin
      unique case (state_r)
        cdde_pkg::S_IDLE: if (take0 || take1) begin
          tbl_r   <= take1;
          sel_r   <= `CDDE_HW_COUNT;
          idx_r   <= 16'h0;
          state_r <= cdde_pkg::S_HRD;
        end
        cdde_pkg::S_HRD: if (!RD) state_r <= cdde_pkg::S_HCAP;
        cdde_pkg::S_HCAP: begin
          sel_r   <= sel_r + 2'h1;
          state_r <= (sel_r == `CDDE_HW_READY) ? cdde_pkg::S_CHECK : cdde_pkg::S_HRD;
        end
        cdde_pkg::S_CHECK:
          state_r <= (idx_r < hdr_ctl_r[`CDDE_F_CNT] && idx_r <= ready_r) ?
                     cdde_pkg::S_FETCH : cdde_pkg::S_IDLE;
        cdde_pkg::S_FETCH: begin
          wcnt_r  <= 2'h0;
          state_r <= cdde_pkg::S_FWAIT;
        end
        cdde_pkg::S_FWAIT: if (DESC_VALID) begin
          wcnt_r <= wcnt_r + 2'h1;
          if (wcnt_r == 2'h3) state_r <= cdde_pkg::S_XFER;
        end
        cdde_pkg::S_XFER: if (XFER_DONE) begin
          state_r <= rpt_en ? cdde_pkg::S_RPT :
                     msi_en ? cdde_pkg::S_MSI : cdde_pkg::S_NEXT;
        end
        cdde_pkg::S_RPT: if (RPT_ACK) begin
          state_r <= msi_en ? cdde_pkg::S_MSI : cdde_pkg::S_NEXT;
        end
        cdde_pkg::S_MSI: if (MSI_ACK) state_r <= cdde_pkg::S_NEXT;
        cdde_pkg::S_NEXT: begin
          idx_r   <= idx_r + 16'h1;
          sel_r   <= `CDDE_HW_READY;
          state_r <= cdde_pkg::S_HRD;
        end
        default: state_r <= cdde_pkg::S_IDLE;
      endcase
    end
  end

  // header snapshot; ready count reread before every descriptor
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      hdr_ctl_r <= `CDDE_RST32;
      base_r    <= 64'h0;
      ready_r   <= 16'h0;
    end else if (state_r == cdde_pkg::S_HCAP) begin
      unique case (sel_r)
        `CDDE_HW_COUNT:   hdr_ctl_r <= mem_q;
        `CDDE_HW_BASE_HI: base_r[63:32] <= mem_q;
        `CDDE_HW_BASE_LO: base_r[31:0] <= mem_q;
        `CDDE_HW_READY:   ready_r <= mem_q[15:0];
      endcase
    end
  end

  // descriptor fetch: read-only access to the host table
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      DESC_RD_REQ  <= 1'b0;
      DESC_RD_ADDR <= 64'h0;
    end else begin
      DESC_RD_REQ  <= state_r == cdde_pkg::S_CHECK &&
                      idx_r < hdr_ctl_r[`CDDE_F_CNT] && idx_r <= ready_r;
      DESC_RD_ADDR <= base_r + `CDDE_DESC_BYTES + {44'h0, idx_r, 4'h0};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_dw
      always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
          d_w_r[g] <= `CDDE_RST32;
        end else if (state_r == cdde_pkg::S_FWAIT && DESC_VALID && wcnt_r == 2'(g)) begin
          d_w_r[g] <= DESC_DATA;
        end
      end
    end
  endgenerate

  // transfer request held until done
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      XFER_REQ       <= 1'b0;
      XFER_TO_HOST   <= 1'b0;
      XFER_EP_ADDR   <= `CDDE_RST32;
      XFER_HOST_ADDR <= 64'h0;
      XFER_BYTES     <= 16'h0;
    end else if (state_r == cdde_pkg::S_FWAIT && DESC_VALID && wcnt_r == 2'h3) begin
      XFER_REQ       <= 1'b1;
      XFER_TO_HOST   <= hdr_ctl_r[`CDDE_F_DIR];
      XFER_EP_ADDR   <= d_w_r[1];
      XFER_HOST_ADDR <= {d_w_r[2], DESC_DATA};
      XFER_BYTES     <= d_w_r[0][`CDDE_F_LEN];
    end else if (XFER_DONE) begin
      XFER_REQ <= 1'b0;
    end
  end

  // done-index report and msi, each held until acknowledged
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      RPT_REQ  <= 1'b0;
      RPT_ADDR <= 64'h0;
      RPT_DATA <= 16'h0;
      MSI_REQ  <= 1'b0;
      MSI_NUM  <= 5'h0;
      MSI_TC   <= 3'h0;
    end else begin
      if (state_r == cdde_pkg::S_XFER && XFER_DONE && rpt_en) begin
        RPT_REQ  <= 1'b1;
        RPT_ADDR <= rpt_loc_r;
        RPT_DATA <= idx_r;
      end else if (RPT_ACK) begin
        RPT_REQ <= 1'b0;
      end
      if (((state_r == cdde_pkg::S_XFER && XFER_DONE && !rpt_en) ||
           (state_r == cdde_pkg::S_RPT && RPT_ACK)) && msi_en) begin
        MSI_REQ <= 1'b1;
        MSI_NUM <= hdr_ctl_r[`CDDE_F_MSINUM];
        MSI_TC  <= hdr_ctl_r[`CDDE_F_MSITC];
      end else if (MSI_ACK) begin
        MSI_REQ <= 1'b0;
      end
    end
  end

  a_xfer_held: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    XFER_REQ && !XFER_DONE |=> XFER_REQ) else $error("transfer request dropped");
  a_len_bytes: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    $rose(XFER_REQ) |-> XFER_BYTES == d_w_r[0][15:0]) else $error("length mismatch");
  a_ep_addr: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    $rose(XFER_REQ) |-> XFER_EP_ADDR == d_w_r[1]) else $error("endpoint address mismatch");
  a_host_addr: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    $rose(XFER_REQ) |-> XFER_HOST_ADDR == {d_w_r[2], $past(DESC_DATA)})
    else $error("host address mismatch");
  a_rpt_enable: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    XFER_REQ && XFER_DONE && (d_w_r[0][16] || hdr_ctl_r[18]) |=> RPT_REQ)
    else $error("report not requested");
  a_rpt_index: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    RPT_REQ |-> RPT_DATA == idx_r) else $error("report index wrong");
  a_msi_after: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    XFER_REQ && XFER_DONE && !rpt_en && (d_w_r[0][17] || hdr_ctl_r[17]) |=> MSI_REQ)
    else $error("msi not requested");
  a_msi_order: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    $rose(MSI_REQ) |-> !XFER_REQ && !RPT_REQ) else $error("msi before transfer end");
  a_dir_route: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    $rose(XFER_REQ) |-> XFER_TO_HOST == hdr_ctl_r[16]) else $error("direction wrong");
  a_fetch_gate: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    DESC_RD_REQ |-> idx_r < hdr_ctl_r[15:0] && idx_r <= ready_r)
    else $error("fetch beyond ready");
  a_fetch_addr: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    DESC_RD_REQ |-> DESC_RD_ADDR == base_r + 64'h10 + {44'h0, idx_r, 4'h0})
    else $error("fetch address wrong");
  a_idx_step: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    state_r == cdde_pkg::S_NEXT |=> idx_r == $past(idx_r) + 16'h1)
    else $error("index skipped");
endmodule // cdde_engine

// ==== test/cdde_host_model.sv ====
// host memory and completer model on the far side of the descriptor engine
`timescale 1ns/100ps
module cdde_host_model (
  input  wire logic        clk,
  input  wire logic [3:0]  dly,
  input  wire logic        desc_rd_req,
  input  wire logic [63:0] desc_rd_addr,
  output logic             desc_valid,
  output logic      [31:0] desc_data,
  input  wire logic        xfer_req,
  output logic             xfer_done,
  input  wire logic        rpt_req,
  output logic             rpt_ack,
  input  wire logic        msi_req,
  output logic             msi_ack
);
  // descriptor list lives here and has no write path from the engine
  logic [31:0] mem [logic [63:0]];
  logic [63:0] a;
  initial begin
    desc_valid = 1'b0;
    desc_data  = 32'h0;
    xfer_done  = 1'b0;
    rpt_ack    = 1'b0;
    msi_ack    = 1'b0;
  end
  initial forever begin
    @(posedge clk);
    if (desc_rd_req === 1'b1) begin
      a = desc_rd_addr;
      repeat (dly) @(posedge clk);
      for (int k = 0; k < 4; k++) begin
        desc_valid <= 1'b1;
        desc_data  <= mem[a + 64'(4 * k)];
        @(posedge clk);
      end
      desc_valid <= 1'b0;
      // released data line shows the inverse of the last word
      desc_data  <= ~desc_data;
    end
  end
  initial forever begin
    @(posedge clk);
    if (xfer_req === 1'b1) begin
      repeat (dly) @(posedge clk);
      xfer_done <= 1'b1;
      @(posedge clk);
      xfer_done <= 1'b0;
      @(posedge clk);
    end
  end
  initial forever begin
    @(posedge clk);
    if (rpt_req === 1'b1) begin
      repeat (dly) @(posedge clk);
      rpt_ack <= 1'b1;
      @(posedge clk);
      rpt_ack <= 1'b0;
      @(posedge clk);
    end
  end
  initial forever begin
    @(posedge clk);
    if (msi_req === 1'b1) begin
      repeat (dly) @(posedge clk);
      msi_ack <= 1'b1;
      @(posedge clk);
      msi_ack <= 1'b0;
      @(posedge clk);
    end
  end
endmodule // cdde_host_model

// ==== test/cdde_engine_tb.sv ====
// self-checking bench for the descriptor engine against a queue model
`timescale 1ns/100ps
module cdde_engine_tb;
  typedef struct {
    int          k;
    logic [63:0] a;
    logic [31:0] b;
    logic [15:0] c;
    logic        d;
  } cdde_ev_t;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [6:0]  addr = 7'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, desc_data, xfer_ep_addr;
  logic [63:0] desc_rd_addr, xfer_host_addr, rpt_addr, fbase, rloc;
  logic [15:0] xfer_bytes, rpt_data;
  logic        desc_rd_req, desc_valid, xfer_req, xfer_to_host, xfer_done;
  logic        rpt_req, rpt_ack, msi_req, msi_ack, irq, xq, rq, mq;
  logic [4:0]  msi_num;
  logic [2:0]  msi_tc;
  logic [3:0]  dly = 4'h0;
  logic [31:0] seed = 32'h0000_CDDD;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          fi = 0;
  cdde_ev_t    evq [$];

  cdde_engine dut (.CLOCK(clock), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .DESC_RD_REQ(desc_rd_req), .DESC_RD_ADDR(desc_rd_addr),
    .DESC_VALID(desc_valid), .DESC_DATA(desc_data), .XFER_REQ(xfer_req),
    .XFER_TO_HOST(xfer_to_host), .XFER_EP_ADDR(xfer_ep_addr), .XFER_HOST_ADDR(xfer_host_addr),
    .XFER_BYTES(xfer_bytes), .XFER_DONE(xfer_done), .RPT_REQ(rpt_req), .RPT_ADDR(rpt_addr),
    .RPT_DATA(rpt_data), .RPT_ACK(rpt_ack), .MSI_REQ(msi_req), .MSI_NUM(msi_num),
    .MSI_TC(msi_tc), .MSI_ACK(msi_ack), .IRQ(irq));
  cdde_host_model host (.clk(clock), .dly(dly), .desc_rd_req(desc_rd_req),
    .desc_rd_addr(desc_rd_addr), .desc_valid(desc_valid), .desc_data(desc_data),
    .xfer_req(xfer_req), .xfer_done(xfer_done), .rpt_req(rpt_req), .rpt_ack(rpt_ack),
    .msi_req(msi_req), .msi_ack(msi_ack));

  always #10 clock = ~clock;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr_reg(logic [6:0] a, logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(logic [6:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic take(int k, logic [63:0] a, logic [31:0] b, logic [15:0] c, logic d);
    cdde_ev_t e;
    if (evq.size() == 0) begin
      chk("unexpected event", 1, 0);
      return;
    end
    e = evq.pop_front();
    chk("event kind", k, e.k);
    chk("address", a, e.a);
    chk("ep address", b, e.b);
    chk("count field", c, e.c);
    chk("direction", d, e.d);
  endtask

  // watch the far-side requests as they rise
  always @(negedge clock) begin
    if (desc_rd_req === 1'b1) begin
      chk("fetch addr", desc_rd_addr, fbase + 64'(16 * fi));
      fi++;
    end
    if (xfer_req === 1'b1 && xq !== 1'b1)
      take(0, xfer_host_addr, xfer_ep_addr, xfer_bytes, xfer_to_host);
    if (rpt_req === 1'b1 && rq !== 1'b1)
      take(1, rpt_addr, 32'h0, rpt_data, 1'b0);
    if (msi_req === 1'b1 && mq !== 1'b1)
      take(2, 64'h0, 32'h0, {8'h00, msi_num, msi_tc}, 1'b0);
    xq = xfer_req;
    rq = rpt_req;
    mq = msi_req;
  end

  task automatic run_table(logic tbl, logic dir, int cnt, int rdy);
    logic [31:0] h, d0, ep, hi, lo, v;
    logic [63:0] base, da;
    logic [6:0]  hb;
    hb   = tbl ? 7'h10 : 7'h00;
    base = {xs(), xs() & 32'hFFFF_FFF0};
    h    = (xs() & 32'h71F6_0000) | {15'h0, dir, 16'(cnt)};
    wr_reg(hb, h);
    wr_reg(hb + 7'h04, base[63:32]);
    wr_reg(hb + 7'h08, base[31:0]);
    wr_reg(hb + 7'h0C, 32'(rdy));
    rd_reg(hb, v);
    chk("header word", v, h);
    for (int i = 0; i < cnt; i++) begin
      d0 = xs();  // reserved bits left random
      ep = xs();
      hi = xs();
      lo = xs();
      da = base + 64'h10 + 64'(16 * i);
      host.mem[da] = d0;
      host.mem[da + 64'h4] = ep;
      host.mem[da + 64'h8] = hi;
      host.mem[da + 64'hC] = lo;
      if (i <= rdy) begin
        evq.push_back(cdde_ev_t'{0, {hi, lo}, ep, d0[15:0], dir});
        if (d0[16] | h[18])
          evq.push_back(cdde_ev_t'{1, rloc, 32'h0, 16'(i), 1'b0});
        if (d0[17] | h[17])
          evq.push_back(cdde_ev_t'{2, 64'h0, 32'h0, {8'h00, h[24:20], h[30:28]}, 1'b0});
      end
    end
    fbase = base + 64'h10;
    fi = 0;
    wr_reg(7'h28, tbl ? 32'h2 : 32'h1);
    for (int w = 0; w < 3000 && irq !== 1'b1; w++) @(posedge clock);
    chk("table irq", irq, 1'b1);
    rd_reg(7'h2C, v);
    chk("stop status", v, {1'b0, tbl, 14'h0, 16'((cnt < rdy + 1) ? cnt : rdy + 1)});
    rd_reg(7'h28, v);
    chk("start pending", v, 32'h0);
    rd_reg(7'h30, v);
    chk("irq status", v, 32'h3);
    wr_reg(7'h34, 32'h0);
    repeat (2) @(posedge clock);
    #1 chk("masked irq", irq, 1'b0);
    wr_reg(7'h34, 32'h2);
    wr_reg(7'h30, 32'h3);
    repeat (2) @(posedge clock);
    #1 chk("cleared irq", irq, 1'b0);
    chk("events left", evq.size(), 0);
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    logic [31:0] v;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    #1 chk("reset irq", irq, 1'b0);
    chk("reset xfer", xfer_req, 1'b0);
    rloc = {xs(), xs() & 32'hFFFF_FFFC};
    wr_reg(7'h20, rloc[31:0]);
    wr_reg(7'h24, rloc[63:32]);
    wr_reg(7'h34, 32'h2);
    rd_reg(7'h40, v);
    chk("unmapped read", v, 32'h0);
    rd_reg(7'h24, v);
    chk("location hi", v, rloc[63:32]);
    for (int t = 0; t < 6; t++) begin
      dly <= 4'(t * 3);
      run_table(t[0], 1'(xs()), 1 + int'(xs() % 4), int'(xs() % 4));
    end
    conclude();
  end
endmodule // cdde_engine_tb
